//--- hdl/xme_defines.svh
// Register offsets, field positions and constants of the extended memory op unit
`ifndef XME_DEFINES_SVH
`define XME_DEFINES_SVH
`define XME_OFS_CMD 8'h00
`define XME_OFS_ACC 8'h04
`define XME_OFS_FLAGS 8'h08
`define XME_OFS_STATUS 8'h0C
`define XME_OFS_TPTR 8'h10
`define XME_OFS_THI 8'h14
`define XME_OFS_PAGE 8'h18
`define XME_MEM_SEL 2'b01
`define XME_MEM_SEL_RANGE 7:6
`define XME_MEM_IDX_RANGE 5:2
`define XME_MEM_DEPTH 16
`define XME_CMD_OP_RANGE 4:0
`define XME_CMD_BIT_RANGE 7:5
`define XME_CMD_ADDR_RANGE 11:8
`define XME_CMD_STRB 2'b11
`define XME_CMD_STRB_RANGE 1:0
`define XME_FLAG_C 0
`define XME_FLAG_HC 1
`define XME_FLAG_Z 2
`define XME_FLAG_RNG 3
`define XME_FLAG_SGN 4
`define XME_FLAG_CHZ 5
`define XME_ST_BUSY 0
`define XME_ST_SKIP 1
`define XME_BYTE_ZERO 8'h00
`define XME_BYTE_ONE 8'h01
`define XME_BYTE_ONES 8'hFF
`define XME_FLAGS_ZERO 6'h00
`define XME_CMD_ZERO 12'h000
`define XME_WORD_ZERO 32'h0000_0000
`define XME_PADDR_ZERO 16'h0000
`endif

//--- hdl/xme_pkg.sv
// Types shared by the extended memory op unit
package xme_pkg;
	typedef enum logic [4:0] {
		XME_ROT_R = 5'h00, XME_ROT_R_ACC = 5'h01, XME_ROT_RC = 5'h02,
		XME_ROT_RC_ACC = 5'h03, XME_SBC_ACC = 5'h04, XME_SBC_MEM = 5'h05,
		XME_SUB_ACC = 5'h06, XME_SUB_MEM = 5'h07, XME_DSZ = 5'h08,
		XME_DSZ_ACC = 5'h09, XME_ISZ = 5'h0A, XME_ISZ_ACC = 5'h0B,
		XME_SET_BYTE = 5'h0C, XME_SET_BIT = 5'h0D, XME_SNZ_BIT = 5'h0E,
		XME_SNZ_BYTE = 5'h0F, XME_SZ_BYTE = 5'h10, XME_SZA = 5'h11,
		XME_SZ_BIT = 5'h12, XME_SWAP = 5'h13, XME_SWAP_ACC = 5'h14,
		XME_TABRD = 5'h15
	} xme_op_t;
	typedef enum logic [1:0] {
		XME_IDLE = 2'b00,
		XME_EXEC = 2'b01,
		XME_DUMMY = 2'b10
	} xme_state_t;
	typedef logic [7:0] xme_byte_t;
	typedef logic [5:0] xme_flags_t;
endpackage : xme_pkg

//--- hdl/xme_alu_if.sv
// Operand and result bundle between sequencer and datapath
`timescale 1ns/1ps
interface xme_alu_if;
	import xme_pkg::*;
	xme_op_t op;
	logic [2:0] bit_sel;
	xme_byte_t operand;
	xme_byte_t acc;
	xme_flags_t flags;
	xme_byte_t result;
	xme_flags_t flags_out;
	logic wr_mem;
	logic wr_acc;
	logic skip;
	modport seq (output op, bit_sel, operand, acc, flags,
		input result, flags_out, wr_mem, wr_acc, skip);
	modport alu (input op, bit_sel, operand, acc, flags,
		output result, flags_out, wr_mem, wr_acc, skip);
endinterface : xme_alu_if

//--- hdl/xme_alu.sv
// Combinational datapath of the extended memory op group
`timescale 1ns/1ps
`include "xme_defines.svh"
module xme_alu
	import xme_pkg::*;
(
	xme_alu_if.alu bus
);
	logic borrow_in;
	logic [8:0] diff;
	logic [4:0] low_diff;
	xme_byte_t mask;
	logic sgn_ovf;
	logic is_sbc;
	assign mask = `XME_BYTE_ONE << bus.bit_sel;
	assign is_sbc = (bus.op == XME_SBC_ACC || bus.op == XME_SBC_MEM);
	// RULE4: inverted carry borrows
	assign borrow_in = is_sbc ? ~bus.flags[`XME_FLAG_C] : 1'b0;
	// RULE7: plain difference
	assign diff = {1'b0, bus.acc} - {1'b0, bus.operand} - {8'h00, borrow_in};
	assign low_diff = {1'b0, bus.acc[3:0]} - {1'b0, bus.operand[3:0]} - {4'h0, borrow_in};
	assign sgn_ovf = (bus.acc[7] ^ bus.operand[7]) & (diff[7] ^ bus.acc[7]);
	always_comb begin
		bus.result = bus.operand;
		bus.flags_out = bus.flags;
		bus.wr_mem = 1'b0;
		bus.wr_acc = 1'b0;
		bus.skip = 1'b0;
		unique case (bus.op)
			// RULE1: rotate in place
			XME_ROT_R: begin
				bus.result = {bus.operand[0], bus.operand[7:1]};
				bus.wr_mem = 1'b1;
			end
			// RULE2: rotate into accumulator
			XME_ROT_R_ACC: begin
				bus.result = {bus.operand[0], bus.operand[7:1]};
				bus.wr_acc = 1'b1;
			end
			// RULE3: nine-bit ring
			XME_ROT_RC, XME_ROT_RC_ACC: begin
				bus.result = {bus.flags[`XME_FLAG_C], bus.operand[7:1]};
				bus.flags_out[`XME_FLAG_C] = bus.operand[0];
				bus.wr_mem = (bus.op == XME_ROT_RC);
				bus.wr_acc = (bus.op == XME_ROT_RC_ACC);
			end
			XME_SBC_ACC, XME_SBC_MEM, XME_SUB_ACC, XME_SUB_MEM: begin
				bus.result = diff[7:0];
				bus.wr_acc = (bus.op == XME_SBC_ACC || bus.op == XME_SUB_ACC);
				bus.wr_mem = (bus.op == XME_SBC_MEM || bus.op == XME_SUB_MEM);
				// RULE5: carry is inverted borrow
				bus.flags_out[`XME_FLAG_C] = ~diff[8];
				// RULE6: arithmetic flags
				bus.flags_out[`XME_FLAG_HC] = ~low_diff[4];
				bus.flags_out[`XME_FLAG_Z] = (diff[7:0] == `XME_BYTE_ZERO);
				bus.flags_out[`XME_FLAG_RNG] = sgn_ovf;
				bus.flags_out[`XME_FLAG_SGN] = sgn_ovf ^ diff[7];
				// Only a carried-in chain looks at the previous zero
				bus.flags_out[`XME_FLAG_CHZ] = (diff[7:0] == `XME_BYTE_ZERO) &
					((is_sbc && bus.flags[`XME_FLAG_C]) ? bus.flags[`XME_FLAG_Z] : 1'b1);
			end
			// RULE9: decrement, RULE11 for the accumulator form
			XME_DSZ, XME_DSZ_ACC: begin
				bus.result = bus.operand - `XME_BYTE_ONE;
				bus.wr_mem = (bus.op == XME_DSZ);
				bus.wr_acc = (bus.op == XME_DSZ_ACC);
				bus.skip = (bus.operand == `XME_BYTE_ONE);
			end
			// RULE10: increment, RULE11 for the accumulator form
			XME_ISZ, XME_ISZ_ACC: begin
				bus.result = bus.operand + `XME_BYTE_ONE;
				bus.wr_mem = (bus.op == XME_ISZ);
				bus.wr_acc = (bus.op == XME_ISZ_ACC);
				bus.skip = (bus.operand == `XME_BYTE_ONES);
			end
			// RULE12: all ones
			XME_SET_BYTE: begin
				bus.result = `XME_BYTE_ONES;
				bus.wr_mem = 1'b1;
			end
			// RULE13: one bit forced
			XME_SET_BIT: begin
				bus.result = bus.operand | mask;
				bus.wr_mem = 1'b1;
			end
			// RULE14: selected bit set
			XME_SNZ_BIT: bus.skip = |(bus.operand & mask);
			// RULE15: any bit set
			XME_SNZ_BYTE: bus.skip = (bus.operand != `XME_BYTE_ZERO);
			// RULE16: whole byte zero
			XME_SZ_BYTE: bus.skip = (bus.operand == `XME_BYTE_ZERO);
			// RULE17: copy then test
			XME_SZA: begin
				bus.wr_acc = 1'b1;
				bus.skip = (bus.operand == `XME_BYTE_ZERO);
			end
			// RULE18: selected bit clear
			XME_SZ_BIT: bus.skip = ~|(bus.operand & mask);
			// RULE19: swap in place, RULE20 into accumulator
			XME_SWAP, XME_SWAP_ACC: begin
				bus.result = {bus.operand[3:0], bus.operand[7:4]};
				bus.wr_mem = (bus.op == XME_SWAP);
				bus.wr_acc = (bus.op == XME_SWAP_ACC);
			end
			default: begin
			end
		endcase
	end
endmodule : xme_alu

//--- hdl/xme_exec.sv
// APB-controlled sequencer, storage and checks of the extended memory op unit
// Functional notes
// RULE1: rotate memory right, bit0 to bit7, no flags
// RULE2: rotate right into accumulator, memory kept
// RULE3: rotate through carry, only carry changes
// RULE4: subtract with inverted carry, acc or memory
// RULE5: carry cleared on negative, set otherwise
// RULE6: subtracts update all six arithmetic flags
// RULE7: plain subtract, acc or memory destination
// RULE8: met skip adds one dummy cycle
// RULE9: decrement memory, skip when zero
// RULE10: increment memory, skip when wrapping zero
// RULE11: accumulator forms keep memory, test accumulator
// RULE12: byte set writes all ones
// RULE13: bit set forces one bit only
// RULE14: skip when selected bit is one
// RULE15: skip when byte is nonzero
// RULE16: skip when byte is zero
// RULE17: copy byte to acc, skip if zero
// RULE18: skip when selected bit is zero
// RULE19: swap nibbles in place
// RULE20: swapped byte to accumulator only
// RULE21: table read: low to memory, high latched
// RULE22: non-skipping ops take one cycle
`timescale 1ns/1ps
`include "xme_defines.svh"
module xme_exec
	import xme_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] prog_addr,
	input wire logic [15:0] prog_data,
	output logic busy
);
	xme_alu_if alu_bus();
	xme_state_t state_reg, state_next;
	xme_op_t op_reg;
	logic [2:0] bit_reg;
	logic [3:0] addr_reg;
	xme_byte_t acc_reg;
	xme_flags_t flags_reg;
	xme_byte_t tptr_reg, page_reg, thi_reg;
	xme_byte_t mem_reg [`XME_MEM_DEPTH];
	logic [11:0] cmd_reg;
	logic skip_reg;
	logic pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic [15:0] prog_addr_reg;
	logic busy_reg;
	logic access, wr_done;
	logic is_mem;
	logic [3:0] mem_idx;
	logic [31:0] rd_mux;
	logic rd_err;
	logic cmd_take;

	// Mapped-address check, shared by read and write decode
	function automatic logic xme_mapped(input logic [7:0] a);
		xme_mapped = (a[`XME_MEM_SEL_RANGE] == `XME_MEM_SEL) ||
			(a == `XME_OFS_CMD) || (a == `XME_OFS_ACC) || (a == `XME_OFS_FLAGS) ||
			(a == `XME_OFS_STATUS) || (a == `XME_OFS_TPTR) ||
			(a == `XME_OFS_THI) || (a == `XME_OFS_PAGE);
	endfunction : xme_mapped

	assign access = psel & penable & ~pready_reg;
	assign wr_done = psel & penable & pready_reg & pwrite & pstrb[0];
	assign is_mem = (paddr[`XME_MEM_SEL_RANGE] == `XME_MEM_SEL);
	assign mem_idx = paddr[`XME_MEM_IDX_RANGE];
	// A command arriving while busy is dropped, never queued
	assign cmd_take = psel & penable & pready_reg & pwrite & (state_reg == XME_IDLE) &
		(pstrb[`XME_CMD_STRB_RANGE] == `XME_CMD_STRB) &
		(paddr == `XME_OFS_CMD);

	assign alu_bus.op = op_reg;
	assign alu_bus.bit_sel = bit_reg;
	assign alu_bus.operand = mem_reg[addr_reg];
	assign alu_bus.acc = acc_reg;
	assign alu_bus.flags = flags_reg;

	xme_alu u_alu (
		.bus(alu_bus.alu)
	);

	always_comb begin
		rd_mux = `XME_WORD_ZERO;
		rd_err = ~xme_mapped(paddr);
		if (is_mem) begin
			rd_mux[7:0] = mem_reg[mem_idx];
		end else begin
			unique case (paddr)
				`XME_OFS_CMD: rd_mux[11:0] = cmd_reg;
				`XME_OFS_ACC: rd_mux[7:0] = acc_reg;
				`XME_OFS_FLAGS: rd_mux[5:0] = flags_reg;
				`XME_OFS_STATUS: begin
					rd_mux[`XME_ST_BUSY] = busy_reg;
					rd_mux[`XME_ST_SKIP] = skip_reg;
				end
				`XME_OFS_TPTR: rd_mux[7:0] = tptr_reg;
				`XME_OFS_THI: rd_mux[7:0] = thi_reg;
				`XME_OFS_PAGE: rd_mux[7:0] = page_reg;
				default: rd_mux = `XME_WORD_ZERO;
			endcase
		end
	end

	// Fixed two-cycle access phase keeps read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= `XME_WORD_ZERO;
		end else begin
			pready_reg <= access;
			pslverr_reg <= access & rd_err;
			if (access && !pwrite) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			XME_IDLE: if (cmd_take) state_next = XME_EXEC;
			// RULE8 RULE22: dummy only on skip
			XME_EXEC: state_next = alu_bus.skip ? XME_DUMMY : XME_IDLE;
			XME_DUMMY: state_next = XME_IDLE;
			default: state_next = XME_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= XME_IDLE;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			busy_reg <= (state_next != XME_IDLE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= `XME_CMD_ZERO;
			op_reg <= XME_ROT_R;
			bit_reg <= 3'h0;
			addr_reg <= 4'h0;
		end else if (cmd_take) begin
			cmd_reg <= pwdata[11:0];
			op_reg <= xme_op_t'(pwdata[`XME_CMD_OP_RANGE]);
			bit_reg <= pwdata[`XME_CMD_BIT_RANGE];
			addr_reg <= pwdata[`XME_CMD_ADDR_RANGE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_reg <= 1'b0;
		end else if (state_reg == XME_EXEC) begin
			skip_reg <= alu_bus.skip;
		end
	end

	// Execution update wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= `XME_BYTE_ZERO;
		end else if (state_reg == XME_EXEC && alu_bus.wr_acc) begin
			acc_reg <= alu_bus.result;
		end else if (wr_done && paddr == `XME_OFS_ACC) begin
			acc_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= `XME_FLAGS_ZERO;
		end else if (state_reg == XME_EXEC) begin
			flags_reg <= alu_bus.flags_out;
		end else if (wr_done && paddr == `XME_OFS_FLAGS) begin
			flags_reg <= pwdata[5:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `XME_MEM_DEPTH; gi++) begin : g_mem
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_reg[gi] <= `XME_BYTE_ZERO;
				end else if (state_reg == XME_EXEC && addr_reg == 4'(gi)) begin
					// RULE21: low byte to memory
					if (op_reg == XME_TABRD) begin
						mem_reg[gi] <= prog_data[7:0];
					end else if (alu_bus.wr_mem) begin
						mem_reg[gi] <= alu_bus.result;
					end
				end else if (wr_done && is_mem && mem_idx == 4'(gi)) begin
					mem_reg[gi] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tptr_reg <= `XME_BYTE_ZERO;
			page_reg <= `XME_BYTE_ZERO;
		end else if (wr_done) begin
			if (paddr == `XME_OFS_TPTR) tptr_reg <= pwdata[7:0];
			if (paddr == `XME_OFS_PAGE) page_reg <= pwdata[7:0];
		end
	end

	// Program address tracks the pointer one cycle late, settled before any command runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_addr_reg <= `XME_PADDR_ZERO;
		end else begin
			prog_addr_reg <= {page_reg, tptr_reg};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thi_reg <= `XME_BYTE_ZERO;
		end else if (state_reg == XME_EXEC && op_reg == XME_TABRD) begin
			// RULE21: high byte latched
			thi_reg <= prog_data[15:8];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prog_addr = prog_addr_reg;
	assign busy = busy_reg;

	property p_skip_dummy;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && alu_bus.skip) |=> (state_reg == XME_DUMMY) ##1
			(state_reg == XME_IDLE);
	endproperty
	a_skip_dummy: assert property (p_skip_dummy) // RULE8
		else $error("skip did not take exactly one dummy cycle");

	property p_one_cycle;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && !alu_bus.skip) |=> (state_reg == XME_IDLE) && !busy_reg;
	endproperty
	a_one_cycle: assert property (p_one_cycle) // RULE22
		else $error("non-skipping op took more than one cycle");

	property p_rot_mem;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_ROT_R) |=>
			(mem_reg[addr_reg] == {$past(alu_bus.operand[0]), $past(alu_bus.operand[7:1])})
			&& $stable(flags_reg);
	endproperty
	a_rot_mem: assert property (p_rot_mem) // RULE1
		else $error("rotate right in memory wrong");

	property p_rot_acc;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_ROT_R_ACC) |=>
			(acc_reg == {$past(alu_bus.operand[0]), $past(alu_bus.operand[7:1])}) &&
			$stable(mem_reg[addr_reg]) && $stable(flags_reg);
	endproperty
	a_rot_acc: assert property (p_rot_acc) // RULE2
		else $error("rotate right to accumulator wrong");

	property p_rot_carry;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_ROT_RC) |=>
			(flags_reg[`XME_FLAG_C] == $past(alu_bus.operand[0])) &&
			(mem_reg[addr_reg][7] == $past(flags_reg[`XME_FLAG_C])) &&
			(flags_reg[5:1] == $past(flags_reg[5:1]));
	endproperty
	a_rot_carry: assert property (p_rot_carry) // RULE3
		else $error("rotate through carry wrong");

	property p_sub_carry;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_SUB_ACC) |=>
			(flags_reg[`XME_FLAG_C] == ($past(acc_reg) >= $past(alu_bus.operand))) &&
			(acc_reg == 8'($past(acc_reg) - $past(alu_bus.operand)));
	endproperty
	a_sub_carry: assert property (p_sub_carry) // RULE5
		else $error("subtract carry or result wrong");

	property p_sbc_mem;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_SBC_MEM) |=>
			(mem_reg[addr_reg] == 8'($past(acc_reg) - $past(alu_bus.operand) -
			{7'h00, ~$past(flags_reg[`XME_FLAG_C])})) && $stable(acc_reg) &&
			(flags_reg[`XME_FLAG_Z] == (mem_reg[addr_reg] == `XME_BYTE_ZERO));
	endproperty
	a_sbc_mem: assert property (p_sbc_mem) // RULE4
		else $error("subtract with borrow to memory wrong");

	property p_dec_skip;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_DSZ) |=>
			(mem_reg[addr_reg] == 8'($past(alu_bus.operand) - `XME_BYTE_ONE)) &&
			((state_reg == XME_DUMMY) == (mem_reg[addr_reg] == `XME_BYTE_ZERO)) &&
			$stable(flags_reg);
	endproperty
	a_dec_skip: assert property (p_dec_skip) // RULE9
		else $error("decrement and skip wrong");

	property p_inc_acc;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_ISZ_ACC) |=>
			(acc_reg == 8'($past(alu_bus.operand) + `XME_BYTE_ONE)) &&
			$stable(mem_reg[addr_reg]) &&
			((state_reg == XME_DUMMY) == (acc_reg == `XME_BYTE_ZERO));
	endproperty
	a_inc_acc: assert property (p_inc_acc) // RULE11
		else $error("increment to accumulator wrong");

	property p_set_byte;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_SET_BYTE) |=>
			(mem_reg[addr_reg] == `XME_BYTE_ONES) && $stable(flags_reg);
	endproperty
	a_set_byte: assert property (p_set_byte) // RULE12
		else $error("byte set wrong");

	property p_bit_zero_skip;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_SZ_BIT) |->
			(alu_bus.skip == !alu_bus.operand[bit_reg]) ##1
			($stable(mem_reg[addr_reg]) && $stable(acc_reg));
	endproperty
	a_bit_zero_skip: assert property (p_bit_zero_skip) // RULE18
		else $error("bit zero test wrong");

	property p_table_read;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == XME_EXEC && op_reg == XME_TABRD) |=>
			(thi_reg == $past(prog_data[15:8])) &&
			(mem_reg[addr_reg] == $past(prog_data[7:0])) && $stable(flags_reg);
	endproperty
	a_table_read: assert property (p_table_read) // RULE21
		else $error("table read wrong");
endmodule : xme_exec

//--- test/test_extended_mem_op_exec_unit.sv
// Self-checking bench of the extended memory op unit, driven over APB
`timescale 1ns/1ps
`include "xme_defines.svh"
module test_extended_mem_op_exec_unit
	import xme_pkg::*;
;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] prog_addr;
	logic [15:0] prog_data;
	logic busy;
	int num_errors;
	int total_checks;
	logic [31:0] rv;
	logic ev;

	xme_exec DUT (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.prog_addr(prog_addr),
		.prog_data(prog_data),
		.busy(busy)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Program memory: word is a scramble of its address
	always @(posedge pclk) begin
		prog_data <= {prog_addr[7:0] ^ 8'h3C, prog_addr[15:8] ^ 8'hC3};
	end

	task complete_run;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// Releases the bus on return; callers let one edge pass before the next setup
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, 4'hF, r, e);
		@(posedge pclk);
	endtask : wr

	task chk_rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0000_0000, 4'hF, d, e);
		@(posedge pclk);
		check(d, x);
		check({31'h0, e}, 32'h0000_0000);
	endtask : chk_rd

	function automatic void model(input xme_op_t op, input logic [2:0] b,
		input logic [7:0] m, input logic [7:0] a, input logic [5:0] f, input logic [15:0] pw,
		output logic [7:0] em, output logic [7:0] ea, output logic [5:0] ef, output logic sk);
		logic [8:0] d;
		logic [4:0] h;
		logic bw;
		logic sbc;
		int sv;
		em = m;
		ea = a;
		ef = f;
		sk = 1'b0;
		sbc = (op == XME_SBC_ACC || op == XME_SBC_MEM);
		bw = sbc ? ~f[0] : 1'b0;
		d = {1'b0, a} - {1'b0, m} - 9'(bw);
		h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(bw);
		sv = int'($signed(a)) - int'($signed(m)) - int'(bw);
		case (op)
			XME_ROT_R: em = {m[0], m[7:1]};
			XME_ROT_R_ACC: ea = {m[0], m[7:1]};
			XME_ROT_RC: em = {f[0], m[7:1]};
			XME_ROT_RC_ACC: ea = {f[0], m[7:1]};
			XME_SBC_ACC, XME_SUB_ACC: ea = d[7:0];
			XME_SBC_MEM, XME_SUB_MEM: em = d[7:0];
			XME_DSZ: em = m - 8'h01;
			XME_DSZ_ACC: ea = m - 8'h01;
			XME_ISZ: em = m + 8'h01;
			XME_ISZ_ACC: ea = m + 8'h01;
			XME_SET_BYTE: em = 8'hFF;
			XME_SET_BIT: em = m | (8'h01 << b);
			XME_SNZ_BIT: sk = m[b];
			XME_SNZ_BYTE: sk = (m != 8'h00);
			XME_SZ_BYTE: sk = (m == 8'h00);
			XME_SZA: ea = m;
			XME_SZ_BIT: sk = ~m[b];
			XME_SWAP: em = {m[3:0], m[7:4]};
			XME_SWAP_ACC: ea = {m[3:0], m[7:4]};
			XME_TABRD: em = pw[7:0];
			default: sk = 1'b0;
		endcase
		if (op == XME_ROT_RC || op == XME_ROT_RC_ACC) begin
			ef[0] = m[0];
		end
		if (op == XME_DSZ || op == XME_ISZ) begin
			sk = (em == 8'h00);
		end
		if (op == XME_DSZ_ACC || op == XME_ISZ_ACC || op == XME_SZA) begin
			sk = (ea == 8'h00);
		end
		if (sbc || op == XME_SUB_ACC || op == XME_SUB_MEM) begin
			ef[0] = ~d[8];
			ef[1] = ~h[4];
			ef[2] = (d[7:0] == 8'h00);
			ef[3] = (sv < -128 || sv > 127);
			ef[4] = ef[3] ^ d[7];
			ef[5] = ef[2] & ((sbc && f[0]) ? f[2] : 1'b1);
		end
	endfunction : model

	task run(input xme_op_t op, input logic [2:0] b, input logic [3:0] i,
		input logic [7:0] m, input logic [7:0] a, input logic [5:0] f);
		logic [7:0] em;
		logic [7:0] ea;
		logic [7:0] nb;
		logic [5:0] ef;
		logic sk;
		logic [31:0] r;
		logic e;
		int n;
		nb = 8'h5A ^ {4'h0, i};
		wr(8'h40 + {2'b00, i, 2'b00}, {24'h0, m});
		wr(8'h40 + {2'b00, i + 4'h1, 2'b00}, {24'h0, nb});
		wr(`XME_OFS_ACC, {24'h0, a});
		wr(`XME_OFS_FLAGS, {26'h0, f});
		model(op, b, m, a, f, {8'hA7 ^ 8'h3C, 8'h12 ^ 8'hC3}, em, ea, ef, sk);
		apb(1'b1, `XME_OFS_CMD, {20'h0, i, b, op}, 4'hF, r, e);
		n = 0;
		@(posedge pclk);
		while (busy === 1'b1 && n < 10) begin
			n++;
			@(posedge pclk);
		end
		check(32'(n), sk ? 32'h0000_0002 : 32'h0000_0001);
		chk_rd(8'h40 + {2'b00, i, 2'b00}, {24'h0, em});
		chk_rd(8'h40 + {2'b00, i + 4'h1, 2'b00}, {24'h0, nb});
		chk_rd(`XME_OFS_ACC, {24'h0, ea});
		chk_rd(`XME_OFS_FLAGS, {26'h0, ef});
		chk_rd(`XME_OFS_STATUS, {30'h0, sk, 1'b0});
	endtask : run

	initial begin
		num_errors = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_rd(`XME_OFS_ACC, 32'h0000_0000);
		chk_rd(`XME_OFS_FLAGS, 32'h0000_0000);
		chk_rd(`XME_OFS_THI, 32'h0000_0000);
		apb(1'b0, 8'hFC, 32'h0000_0000, 4'hF, rv, ev);
		@(posedge pclk);
		check(rv, 32'h0000_0000);
		check({31'h0, ev}, 32'h0000_0001);
		// Lane 0 off: write must not land
		apb(1'b1, `XME_OFS_ACC, 32'h0000_0077, 4'hE, rv, ev);
		@(posedge pclk);
		chk_rd(`XME_OFS_ACC, 32'h0000_0000);
		wr(`XME_OFS_THI, 32'h0000_00FF);
		chk_rd(`XME_OFS_THI, 32'h0000_0000);
		wr(`XME_OFS_TPTR, 32'h0000_00A7);
		wr(`XME_OFS_PAGE, 32'h0000_0012);
		// Program address follows the pointer one edge late
		@(posedge pclk);
		check({16'h0, prog_addr}, 32'h0000_12A7);
		run(XME_ROT_R, 3'h0, 4'h0, 8'h01, 8'h00, 6'h00);
		run(XME_ROT_R_ACC, 3'h0, 4'h1, 8'hA3, 8'h00, 6'h3F);
		run(XME_ROT_RC, 3'h0, 4'h2, 8'h81, 8'h00, 6'h00);
		run(XME_ROT_RC_ACC, 3'h0, 4'h3, 8'h02, 8'h11, 6'h01);
		run(XME_SBC_ACC, 3'h0, 4'h4, 8'h10, 8'h10, 6'h00);
		run(XME_SBC_MEM, 3'h0, 4'h5, 8'h10, 8'h10, 6'h05);
		run(XME_SBC_ACC, 3'h0, 4'h6, 8'h01, 8'h80, 6'h01);
		run(XME_SUB_ACC, 3'h0, 4'h7, 8'h01, 8'h80, 6'h00);
		run(XME_SUB_MEM, 3'h0, 4'h8, 8'h07, 8'h05, 6'h3F);
		run(XME_SUB_ACC, 3'h0, 4'h9, 8'h00, 8'h00, 6'h00);
		run(XME_SUB_MEM, 3'h0, 4'h0, 8'h22, 8'h22, 6'h01);
		run(XME_DSZ, 3'h0, 4'hA, 8'h01, 8'h00, 6'h2A);
		run(XME_DSZ, 3'h0, 4'hB, 8'h00, 8'h00, 6'h00);
		run(XME_DSZ_ACC, 3'h0, 4'hC, 8'h01, 8'h33, 6'h00);
		run(XME_ISZ, 3'h0, 4'hD, 8'hFF, 8'h00, 6'h15);
		run(XME_ISZ, 3'h0, 4'hE, 8'h7F, 8'h00, 6'h00);
		run(XME_ISZ_ACC, 3'h0, 4'hF, 8'hFF, 8'h44, 6'h2A);
		run(XME_SET_BYTE, 3'h0, 4'h0, 8'h00, 8'h00, 6'h15);
		run(XME_SET_BIT, 3'h7, 4'h1, 8'h00, 8'h00, 6'h00);
		run(XME_SET_BIT, 3'h0, 4'h2, 8'hFE, 8'h00, 6'h3F);
		run(XME_SNZ_BIT, 3'h3, 4'h3, 8'h08, 8'h00, 6'h00);
		run(XME_SNZ_BIT, 3'h3, 4'h4, 8'hF7, 8'h00, 6'h00);
		run(XME_SNZ_BYTE, 3'h0, 4'h5, 8'h80, 8'h00, 6'h00);
		run(XME_SNZ_BYTE, 3'h0, 4'h6, 8'h00, 8'h00, 6'h00);
		run(XME_SZ_BYTE, 3'h0, 4'h7, 8'h00, 8'h00, 6'h00);
		run(XME_SZ_BYTE, 3'h0, 4'h8, 8'h01, 8'h00, 6'h00);
		run(XME_SZA, 3'h0, 4'h9, 8'h00, 8'h66, 6'h00);
		run(XME_SZA, 3'h0, 4'hA, 8'h5A, 8'h00, 6'h00);
		run(XME_SZ_BIT, 3'h0, 4'hB, 8'hFE, 8'h00, 6'h00);
		run(XME_SZ_BIT, 3'h7, 4'hC, 8'h80, 8'h00, 6'h00);
		run(XME_SWAP, 3'h0, 4'hD, 8'h1E, 8'h00, 6'h00);
		run(XME_SWAP_ACC, 3'h0, 4'hE, 8'hC3, 8'h00, 6'h00);
		run(XME_TABRD, 3'h0, 4'hF, 8'h00, 8'h00, 6'h3F);
		chk_rd(`XME_OFS_THI, {24'h0, 8'hA7 ^ 8'h3C});
		complete_run;
	end

	// A hung handshake ends the run as a failure
	initial begin
		repeat (8000) @(posedge pclk);
		num_errors++;
		complete_run;
	end
endmodule : test_extended_mem_op_exec_unit
